//--- common/lms_pkg.sv
package lms_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int unsigned NUM_LINES = 16;
    localparam int unsigned LINE_W = 4;
    localparam int unsigned STAT_W = 4;
    localparam int unsigned ADR_W = 8;
    localparam int unsigned DAT_W = 32;
    localparam int unsigned REG_W = 16;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] LINE_CTRL_OFF = 8'h00;
    localparam logic [7:0] SCAN_CTRL_OFF = 8'h04;
    localparam logic [7:0] LEN_OFF = 8'h08;
    localparam logic [7:0] MST_OFF = 8'h0C;

    // ****************************************
    // Line control register fields
    // ****************************************
    localparam int unsigned LINE_SEL_LSB = 0;
    localparam int unsigned MNT_INT_BIT = 9;
    localparam int unsigned MNT_EXT_BIT = 10;
    localparam int unsigned MNT_EN_BIT = 11;
    localparam int unsigned LINE_STROBE_BIT = 15;

    // ****************************************
    // Scan control/status register fields
    // ****************************************
    localparam int unsigned SCAN_DONE_BIT = 7;
    localparam int unsigned SCAN_STEP_BIT = 8;
    localparam int unsigned SCAN_FORCE_BIT = 9;
    localparam int unsigned SCAN_LINE_LSB = 12;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] LINE_CTRL_RST = 16'h0000;
    localparam logic [15:0] LEN_RST = 16'h0000;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_INTERNAL = 2'b01,
        MODE_EXTERNAL = 2'b10
    } lms_mode_t;

    typedef enum logic {
        SCAN_IDLE = 1'b0,
        SCAN_CHECK = 1'b1
    } lms_scan_st_t;

endpackage : lms_pkg

//--- hw/lms_modem_scan.sv
`timescale 1ns/1ps
module lms_modem_scan #(
    parameter int unsigned NUM_LINES = lms_pkg::NUM_LINES,
    parameter int unsigned LINE_W = lms_pkg::LINE_W,
    parameter int unsigned STAT_W = lms_pkg::STAT_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic step_i,
    input wire logic done_clr_i,
    input wire logic force_i,
    input wire logic [NUM_LINES-1:0] line_en_i,
    // Modem status
    input wire logic [NUM_LINES*STAT_W-1:0] status_i,
    // Scanner state
    output logic done_o,
    output logic [LINE_W-1:0] cur_line_o,
    output logic [STAT_W-1:0] cur_status_o
);
    import lms_pkg::*;

    // ****************************************
    // Effective status per line
    // ****************************************
    logic [STAT_W-1:0] eff [NUM_LINES];

    for (genvar g = 0; g < NUM_LINES; g++) begin : g_eff
        always_comb begin
            // Disabled lines are still stepped over and checked, but read as zero
            if (!line_en_i[g]) begin
                eff[g] = '0;
            end else if (force_i) begin
                eff[g] = '1;
            end else begin
                eff[g] = status_i[g*STAT_W +: STAT_W];
            end
        end
    end

    // ****************************************
    // Scan pointer and transition check
    // ****************************************
    lms_scan_st_t st_q, st_d;
    logic [LINE_W-1:0] line_q, line_d;
    logic done_q, done_d;
    logic [STAT_W-1:0] last_q [NUM_LINES];
    logic [STAT_W-1:0] last_d [NUM_LINES];

    always_comb begin
        st_d = st_q;
        line_d = line_q;
        last_d = last_q;
        done_d = done_q & ~done_clr_i;
        case (st_q)
            SCAN_IDLE: begin
                st_d = SCAN_IDLE;
            end
            SCAN_CHECK: begin
                st_d = SCAN_IDLE;
                // Set after the clear, so a same-cycle event wins
                if (eff[line_q] != last_q[line_q]) begin
                    done_d = 1'b1;
                    last_d[line_q] = eff[line_q];
                end
            end
            default: begin
                st_d = SCAN_IDLE;
            end
        endcase
        // Done never blocks stepping
        if (step_i) begin
            if (line_q == LINE_W'(NUM_LINES - 1)) begin
                line_d = '0;
            end else begin
                line_d = line_q + LINE_W'(1);
            end
            st_d = SCAN_CHECK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= SCAN_IDLE;
            line_q <= '0;
            done_q <= 1'b0;
            for (int i = 0; i < NUM_LINES; i++) begin
                last_q[i] <= '0;
            end
        end else begin
            st_q <= st_d;
            line_q <= line_d;
            done_q <= done_d;
            last_q <= last_d;
        end
    end

    assign done_o = done_q;
    assign cur_line_o = line_q;
    assign cur_status_o = eff[line_q];

endmodule : lms_modem_scan

//--- hw/lms_top.sv
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module lms_top #(
    parameter int unsigned NUM_LINES = lms_pkg::NUM_LINES,
    parameter int unsigned LINE_W = lms_pkg::LINE_W,
    parameter int unsigned STAT_W = lms_pkg::STAT_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [lms_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [lms_pkg::DAT_W-1:0] dat_i,
    output logic [lms_pkg::DAT_W-1:0] dat_o,
    output logic ack_o,
    // Serial lines, logic level
    input wire logic [NUM_LINES-1:0] tx_ser_i,
    input wire logic [NUM_LINES-1:0] rx_line_i,
    output logic [NUM_LINES-1:0] rx_ser_o,
    output logic [NUM_LINES-1:0] tx_line_o,
    output logic [NUM_LINES-1:0] line_drv_en_o,
    // Modem status
    input wire logic [NUM_LINES*STAT_W-1:0] modem_status_i
);
    import lms_pkg::*;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic reg_hit(input logic [ADR_W-1:0] a, input logic [7:0] off);
        return a[ADR_W-1:2] == off[ADR_W-1:2];
    endfunction : reg_hit

    function automatic lms_mode_t mode_of(input logic [REG_W-1:0] ctrl);
        lms_mode_t m;
        m = MODE_NORMAL;
        if (ctrl[MNT_EN_BIT] && ctrl[MNT_INT_BIT]) begin
            m = MODE_INTERNAL;
        end else if (ctrl[MNT_EN_BIT] && ctrl[MNT_EXT_BIT]) begin
            m = MODE_EXTERNAL;
        end
        return m;
    endfunction : mode_of

    // ****************************************
    // Bus slave
    // ****************************************
    logic ack_q, ack_d;
    logic [DAT_W-1:0] dat_q, dat_d;
    logic req, wr;
    logic wr_line_ctrl, wr_scan, wr_len;

    // One wait state: answer lands one edge after the request is seen
    assign req = cyc_i & stb_i & ~ack_q;
    // Writes land at the ack edge, where the master sees them done
    assign wr = cyc_i & stb_i & we_i & ack_q;
    assign wr_line_ctrl = wr & reg_hit(adr_i, LINE_CTRL_OFF);
    assign wr_scan = wr & reg_hit(adr_i, SCAN_CTRL_OFF);
    assign wr_len = wr & reg_hit(adr_i, LEN_OFF);

    // ****************************************
    // Line control register
    // ****************************************
    logic [REG_W-1:0] line_ctrl_q, line_ctrl_d;
    logic [REG_W-1:0] len_q, len_d;

    always_comb begin
        line_ctrl_d = line_ctrl_q;
        // Strobe clears on the same edge the line paths take the settings
        if (line_ctrl_q[LINE_STROBE_BIT]) begin
            line_ctrl_d[LINE_STROBE_BIT] = 1'b0;
        end
        if (wr_line_ctrl && sel_i[0]) begin
            line_ctrl_d[7:0] = dat_i[7:0];
        end
        if (wr_line_ctrl && sel_i[1]) begin
            line_ctrl_d[15:8] = dat_i[15:8];
        end
        len_d = len_q;
        if (wr_len && sel_i[0]) begin
            len_d[7:0] = dat_i[7:0];
        end
        if (wr_len && sel_i[1]) begin
            len_d[15:8] = dat_i[15:8];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_ctrl_q <= LINE_CTRL_RST;
            len_q <= LEN_RST;
        end else begin
            line_ctrl_q <= line_ctrl_d;
            len_q <= len_d;
        end
    end

    // ****************************************
    // Per-line maintenance paths
    // ****************************************
    lms_mode_t mode_q [NUM_LINES];
    lms_mode_t mode_d [NUM_LINES];
    logic [NUM_LINES-1:0] rx_q, rx_d;
    logic [NUM_LINES-1:0] tx_q, tx_d;
    logic [NUM_LINES-1:0] drv_q, drv_d;

    for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
        always_comb begin
            mode_d[g] = mode_q[g];
            // Only the line named in the select field is changed
            if (line_ctrl_q[LINE_STROBE_BIT] && line_ctrl_q[LINE_SEL_LSB +: LINE_W] == LINE_W'(g)) begin
                mode_d[g] = mode_of(line_ctrl_q);
            end
            case (mode_q[g])
                MODE_INTERNAL: begin
                    // Loop stays inside; drivers idle at mark
                    rx_d[g] = tx_ser_i[g];
                    tx_d[g] = 1'b1;
                    drv_d[g] = 1'b0;
                end
                MODE_EXTERNAL: begin
                    // Converters stay in path so the plug exercises them
                    rx_d[g] = rx_line_i[g];
                    tx_d[g] = tx_ser_i[g];
                    drv_d[g] = 1'b1;
                end
                default: begin
                    rx_d[g] = rx_line_i[g];
                    tx_d[g] = tx_ser_i[g];
                    drv_d[g] = 1'b1;
                end
            endcase
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                mode_q[g] <= MODE_NORMAL;
                rx_q[g] <= 1'b1;
                tx_q[g] <= 1'b1;
                drv_q[g] <= 1'b1;
            end else begin
                mode_q[g] <= mode_d[g];
                rx_q[g] <= rx_d[g];
                tx_q[g] <= tx_d[g];
                drv_q[g] <= drv_d[g];
            end
        end
    end

    // ****************************************
    // Scan control/status register
    // ****************************************
    logic force_q, force_d;
    logic step;
    logic done_clr;
    logic scan_done;
    logic [LINE_W-1:0] scan_line;
    logic [STAT_W-1:0] scan_status;

    assign step = wr_scan & sel_i[1] & dat_i[SCAN_STEP_BIT];
    assign done_clr = wr_scan & sel_i[0] & dat_i[SCAN_DONE_BIT];

    always_comb begin
        force_d = force_q;
        if (wr_scan && sel_i[1]) begin
            force_d = dat_i[SCAN_FORCE_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            force_q <= 1'b0;
        end else begin
            force_q <= force_d;
        end
    end

    lms_modem_scan #(
        .NUM_LINES(NUM_LINES),
        .LINE_W(LINE_W),
        .STAT_W(STAT_W)
    ) u_scan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .step_i(step),
        .done_clr_i(done_clr),
        .force_i(force_q),
        .line_en_i(len_q[NUM_LINES-1:0]),
        .status_i(modem_status_i),
        .done_o(scan_done),
        .cur_line_o(scan_line),
        .cur_status_o(scan_status)
    );

    // ****************************************
    // Read mux and answer
    // ****************************************
    always_comb begin
        ack_d = req;
        dat_d = dat_q;
        if (req && !we_i) begin
            dat_d = '0;
            if (reg_hit(adr_i, LINE_CTRL_OFF)) begin
                dat_d[REG_W-1:0] = line_ctrl_q;
            end else if (reg_hit(adr_i, SCAN_CTRL_OFF)) begin
                dat_d[SCAN_DONE_BIT] = scan_done;
                dat_d[SCAN_FORCE_BIT] = force_q;
                dat_d[SCAN_LINE_LSB +: LINE_W] = scan_line;
            end else if (reg_hit(adr_i, LEN_OFF)) begin
                dat_d[REG_W-1:0] = len_q;
            end else if (reg_hit(adr_i, MST_OFF)) begin
                dat_d[STAT_W-1:0] = scan_status;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign rx_ser_o = rx_q;
    assign tx_line_o = tx_q;
    assign line_drv_en_o = drv_q;

endmodule : lms_top

//--- verif/lms_top_asserts.sv
`timescale 1ns/1ps
// ****
// Checker
// ****
module lms_top_asserts #(
    parameter int unsigned NUM_LINES = 16
) (
    // Clock, reset, bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [lms_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [lms_pkg::DAT_W-1:0] dat_i,
    input wire logic [lms_pkg::DAT_W-1:0] dat_o,
    input wire logic ack_o,
    // Lines
    input wire logic [NUM_LINES-1:0] tx_ser_i,
    input wire logic [NUM_LINES-1:0] rx_line_i,
    input wire logic [NUM_LINES-1:0] rx_ser_o,
    input wire logic [NUM_LINES-1:0] tx_line_o,
    input wire logic [NUM_LINES-1:0] line_drv_en_o
);
    logic stb_wr;
    assign stb_wr = cyc_i && stb_i && we_i && ack_o && adr_i[7:2] == 6'h00 && sel_i[1] && dat_i[15];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    AST_RD_UPPER: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    AST_RST_OUT: assert property ($past(rst_i) |-> !ack_o && &rx_ser_o && &tx_line_o && &line_drv_en_o)
        else $error("reset state wrong");
    AST_INT_LOOP: assert property (!$past(rst_i) |-> ((rx_ser_o ^ $past(tx_ser_i)) & ~line_drv_en_o) == '0)
        else $error("internal loop broken");
    AST_INT_MARK: assert property ((tx_line_o | line_drv_en_o) == '1)
        else $error("line not at mark");
    AST_EXT_PATH: assert property (!$past(rst_i) |-> ((rx_ser_o ^ $past(rx_line_i)) & line_drv_en_o) == '0
        && ((tx_line_o ^ $past(tx_ser_i)) & line_drv_en_o) == '0)
        else $error("converter path broken");
    AST_MODE_HOLD: assert property (!$stable(line_drv_en_o) && !$past(rst_i) |-> $past(stb_wr, 3))
        else $error("mode moved without strobe");
    cover property (stb_wr);
    cover property (ack_o && !we_i);
    cover property (line_drv_en_o != '1);
endmodule : lms_top_asserts

//--- verif/lms_plug.sv
`timescale 1ns/1ps
// ****
// Turnaround plug
// ****
module lms_plug #(
    parameter int unsigned NUM_LINES = 16
) (
    input wire logic clk_i,
    input wire logic [NUM_LINES-1:0] tx_line_i,
    input wire logic [NUM_LINES-1:0] drv_en_i,
    output logic [NUM_LINES-1:0] rx_line_o
);
    logic [NUM_LINES-1:0] last_q = '0;
    always_ff @(posedge clk_i) last_q <= rx_line_o;
    // Undriven line floats: toggle so stale data cannot pass
    assign rx_line_o = (tx_line_i & drv_en_i) | (~last_q & ~drv_en_i);
endmodule : lms_plug

//--- verif/line_maintenance_loopback_scan_step_tb.sv
`timescale 1ns/1ps
// ****
// Bench
// ****
module line_maintenance_loopback_scan_step_tb;
    import lms_pkg::*;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic [15:0] tx_ser_i, rx_line_i, rx_ser_o, tx_line_o, line_drv_en_o;
    logic [63:0] modem_status_i, ms;
    logic [15:0] eq[$];
    logic [15:0] line_ctrl_tab[6] = '{16'h0A05, 16'h8A03, 16'h8C05, 16'h8E06, 16'h8003, 16'h8806};
    logic [15:0] tx_h1, tx_h2;
    logic [15:0] drv_tab[6] = '{16'hFFFF, 16'hFFF7, 16'hFFF7, 16'hFFB7, 16'hFFBF, 16'hFFFF};
    int errors, num_checks, cyc_cnt, i;
    lms_top u_lms_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tx_ser_i(tx_ser_i),
        .rx_line_i(rx_line_i), .rx_ser_o(rx_ser_o), .tx_line_o(tx_line_o), .line_drv_en_o(line_drv_en_o),
        .modem_status_i(modem_status_i));
    lms_plug u_lms_plug (.clk_i(clk_i), .tx_line_i(tx_line_o), .drv_en_i(line_drv_en_o), .rx_line_o(rx_line_i));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task end_sim();
        if (eq.size() != 0) begin
            errors++;
            $display("ERROR %0t: %0d reads unanswered", $time, eq.size());
        end
        $display("errors=%0d num_checks=%0d", errors, num_checks);
        if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'h3;
        adr_i <= a;
        dat_i <= {16'h0000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task rd(input logic [7:0] a, input logic [15:0] e);
        eq.push_back(e);
        wb(1'b0, a, 16'h0000);
    endtask : rd
    always @(posedge clk_i) begin
        tx_ser_i <= 16'($urandom());
        tx_h1 <= tx_ser_i;
        tx_h2 <= tx_h1;
        if (ack_o === 1'b1 && we_i === 1'b0) begin
            if (eq.size() == 0) begin
                errors++;
                $display("ERROR %0t: unexpected read", $time);
            end else chk(dat_o[15:0], eq.pop_front());
        end
        cyc_cnt++;
        if (cyc_cnt == 4000) begin
            errors++;
            $display("ERROR %0t: timeout", $time);
            end_sim();
        end
    end
    initial begin
        rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00; sel_i = 4'h3;
        dat_i = 32'h0; modem_status_i = 64'h0; errors = 0; num_checks = 0; cyc_cnt = 0;
        void'($urandom(78359));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(LINE_CTRL_OFF, LINE_CTRL_RST);
        rd(LEN_OFF, LEN_RST);
        rd(SCAN_CTRL_OFF, 16'h0000);
        wb(1'b1, 8'h10, 16'hFFFF);
        rd(8'h10, 16'h0000);
        for (i = 0; i < 6; i++) begin
            wb(1'b1, LINE_CTRL_OFF, line_ctrl_tab[i]);
            rd(LINE_CTRL_OFF, line_ctrl_tab[i] & 16'h7FFF);
            chk(line_drv_en_o, drv_tab[i]);
            chk(tx_line_o | line_drv_en_o, 16'hFFFF);
            // Looped lines echo one cycle late, plugged lines two
            repeat (2) begin
                @(posedge clk_i);
                chk(rx_ser_o, (tx_h2 & drv_tab[i]) | (tx_h1 & ~drv_tab[i]));
            end
        end
        ms = {32'($urandom()), 32'($urandom())};
        ms[11:4] = 8'h05;
        modem_status_i <= ms;
        wb(1'b1, LEN_OFF, 16'h0006);
        wb(1'b1, SCAN_CTRL_OFF, 16'h0100);
        rd(SCAN_CTRL_OFF, 16'h1080);
        wb(1'b1, SCAN_CTRL_OFF, 16'h0100);
        rd(SCAN_CTRL_OFF, 16'h2080);
        rd(MST_OFF, 16'h0000);
        wb(1'b1, SCAN_CTRL_OFF, 16'h0280);
        rd(SCAN_CTRL_OFF, 16'h2200);
        rd(MST_OFF, 16'h000F);
        for (i = 0; i < 15; i++) wb(1'b1, SCAN_CTRL_OFF, 16'h0300);
        rd(SCAN_CTRL_OFF, 16'h1280);
        rd(MST_OFF, 16'h000F);
        wb(1'b1, LINE_CTRL_OFF, 16'h8A03);
        repeat (2) @(posedge clk_i);
        chk(line_drv_en_o, 16'hFFF7);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(line_drv_en_o, 16'hFFFF);
        rd(LINE_CTRL_OFF, 16'h0000);
        end_sim();
    end
endmodule : line_maintenance_loopback_scan_step_tb
bind lms_top lms_top_asserts #(.NUM_LINES(NUM_LINES)) u_lms_top_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .tx_ser_i(tx_ser_i), .rx_line_i(rx_line_i), .rx_ser_o(rx_ser_o), .tx_line_o(tx_line_o),
    .line_drv_en_o(line_drv_en_o));
